/* rtl/sram_settings_readback.sv */
// APB-reached run-time settings store, readback reply builder and indicator pin drivers.

module sram_settings_readback #(
   parameter logic [7:0] CHIP_AREA_LEN = 8'h16,
   parameter logic [7:0] GP_AREA_LEN   = 8'h04,
   parameter int         DIV_COUNT_W   = 9
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        rx_busy,
   input  wire logic        tx_busy,
   input  wire logic        twowire_busy,
   input  wire logic        twowire_indicator_enable,
   input  wire logic        usb_suspended,
   input  wire logic        suspend_indicator_enable,
   input  wire logic        usb_configured,
   input  wire logic        enumeration_indicator_enable,
   input  wire logic        clock_output_enable,
   input  wire logic        usb_clk_tick,
   output logic             rx_activity_indicator,
   output logic             tx_activity_indicator,
   output logic             twowire_activity_indicator,
   output logic             suspend_indicator,
   output logic             enumeration_done_indicator,
   output logic             serial_number_enable,
   output logic [1:0]       security_state,
   output logic             clock_output
);
   import settings_readback_pkg::*;

   logic [7:0]             chip_byte_reg;
   logic [DIV_W-1:0]       clock_div_reg;
   logic [7:0]             command_reg;
   logic [31:0]            reply_low_reg;
   logic [15:0]            reply_high_reg;
   reply_state_type        reply_state_reg;
   logic [31:0]            prdata_reg;
   logic                   pslverr_reg;
   logic                   setup_phase;
   logic                   access_done;
   logic                   write_refused;
   logic                   do_write;
   logic                   get_command;
   logic                   reply_consumed;
   logic [INDICATOR_N-1:0] idle_level;
   logic [INDICATOR_N-1:0] activity;
   logic [INDICATOR_N-1:0] indicator_enable;
   logic [INDICATOR_N-1:0] indicator_reg;

   generate
      if (DIV_COUNT_W < DIV_COUNT_MIN_W) begin : g_bad_div_width
         $error("sram_settings_readback: DIV_COUNT_W too small for the divider");
      end
   endgenerate

   // Address decode for the error answer; the read mux keeps its own case on the same offsets.
   function automatic logic reg_known(input logic [7:0] addr);
      reg_known = (addr == OFS_COMMAND) || (addr == OFS_CHIP_SETTINGS) ||
                  (addr == OFS_REPLY_LOW) || (addr == OFS_REPLY_HIGH) ||
                  (addr == OFS_STATUS);
   endfunction : reg_known

   function automatic logic reg_writable(input logic [7:0] addr);
      reg_writable = (addr == OFS_COMMAND) || (addr == OFS_CHIP_SETTINGS);
   endfunction : reg_writable

   function automatic logic [31:0] read_mux(input logic [7:0] addr);
      read_mux = '0;
      case (addr)
         OFS_COMMAND:       read_mux = {24'h000000, command_reg};
         OFS_CHIP_SETTINGS: read_mux = {16'h0000, DIV_PAD_W'(0), clock_div_reg, chip_byte_reg};
         OFS_REPLY_LOW:     read_mux = reply_low_reg;
         OFS_REPLY_HIGH:    read_mux = {16'h0000, reply_high_reg};
         OFS_STATUS:        read_mux = {31'h00000000, reply_state_reg == reply_full};
         default:           read_mux = '0;
      endcase
   endfunction : read_mux

   // A locked part refuses new settings, and the unused security code is never stored.
   always_comb begin
      write_refused = 1'b0;
      if (!reg_known(paddr)) begin
         write_refused = 1'b1;
      end else if (pwrite && !reg_writable(paddr)) begin
         write_refused = 1'b1;
      end else if (pwrite && (paddr == OFS_CHIP_SETTINGS)) begin
         if (security_type'(chip_byte_reg[SEC_MSB:SEC_LSB]) == sec_locked) begin
            write_refused = 1'b1;
         end else if (pstrb[LANE_CHIP] && (pwdata[SEC_MSB:SEC_LSB] == 2'b11)) begin
            write_refused = 1'b1;
         end
      end
   end

   assign pready         = 1'b1;
   assign setup_phase    = psel && !penable;
   assign access_done    = psel && penable && pready;
   assign do_write       = access_done && pwrite && !write_refused;
   assign get_command    = do_write && (paddr == OFS_COMMAND) && pstrb[LANE_CHIP] &&
                           (pwdata[LANE_W-1:0] == CMD_GET_SETTINGS);
   assign reply_consumed = access_done && !pwrite && (paddr == OFS_REPLY_HIGH);

   // Read data and the error answer are prepared in the setup cycle for a zero-wait access.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg  <= '0;
         pslverr_reg <= 1'b0;
      end else if (setup_phase) begin
         prdata_reg  <= pwrite ? 32'h00000000 : read_mux(paddr);
         pslverr_reg <= write_refused;
      end
   end

   assign prdata  = prdata_reg;
   assign pslverr = pslverr_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chip_byte_reg <= CHIP_BYTE_RESET;
         clock_div_reg <= CLOCK_DIV_RESET;
      end else if (do_write && (paddr == OFS_CHIP_SETTINGS)) begin
         if (pstrb[LANE_CHIP]) begin
            chip_byte_reg <= pwdata[LANE_W-1:0];
         end
         if (pstrb[LANE_DIV]) begin
            clock_div_reg <= pwdata[LANE_W+DIV_W-1:LANE_W];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         command_reg <= COMMAND_RESET;
      end else if (do_write && (paddr == OFS_COMMAND) && pstrb[LANE_CHIP]) begin
         command_reg <= pwdata[LANE_W-1:0];
      end
   end

   // The reply is a snapshot, so settings written later do not disturb a pending readback.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reply_low_reg  <= '0;
         reply_high_reg <= '0;
      end else if (get_command) begin
         reply_low_reg  <= {GP_AREA_LEN, CHIP_AREA_LEN,
                            STATUS_SUCCESS, CMD_GET_SETTINGS};
         reply_high_reg <= {DIV_PAD_W'(0),
                            clock_div_reg,
                            chip_byte_reg};
      end
   end

   // A new command wins over a read that consumes the old reply in the same cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reply_state_reg <= reply_empty;
      end else begin
         case (reply_state_reg)
            reply_empty: begin
               if (get_command) begin
                  reply_state_reg <= reply_full;
               end
            end
            reply_full: begin
               if (!get_command && reply_consumed) begin
                  reply_state_reg <= reply_empty;
               end
            end
            default: reply_state_reg <= reply_empty;
         endcase
      end
   end

   assign idle_level[0]       = chip_byte_reg[BIT_RX_IDLE];
   assign activity[0]         = rx_busy;
   assign indicator_enable[0] = 1'b1;
   assign idle_level[1]       = chip_byte_reg[BIT_TX_IDLE];
   assign activity[1]         = tx_busy;
   assign indicator_enable[1] = 1'b1;
   assign idle_level[2]       = chip_byte_reg[BIT_TW_IDLE];
   assign activity[2]         = twowire_busy;
   assign indicator_enable[2] = twowire_indicator_enable;
   assign idle_level[3]       = chip_byte_reg[BIT_SUSP_IDLE];
   assign activity[3]         = usb_suspended;
   assign indicator_enable[3] = suspend_indicator_enable;
   assign idle_level[4]       = chip_byte_reg[BIT_ENUM_IDLE];
   assign activity[4]         = usb_configured;
   assign indicator_enable[4] = enumeration_indicator_enable;

   // A disabled indicator rests at its idle level instead of floating.
   genvar gi;
   generate
      for (gi = 0; gi < INDICATOR_N; gi++) begin : g_indicator
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               indicator_reg[gi] <= 1'b0;
            end else begin
               indicator_reg[gi] <= idle_level[gi] ^ (indicator_enable[gi] && activity[gi]);
            end
         end
      end
   endgenerate

   assign rx_activity_indicator      = indicator_reg[0];
   assign tx_activity_indicator      = indicator_reg[1];
   assign twowire_activity_indicator = indicator_reg[2];
   assign suspend_indicator          = indicator_reg[3];
   assign enumeration_done_indicator = indicator_reg[4];
   assign serial_number_enable       = chip_byte_reg[BIT_SERIAL_EN];
   assign security_state             = chip_byte_reg[SEC_MSB:SEC_LSB];

   clock_output_divider #(
      .COUNT_W (DIV_COUNT_W)
   ) u_clock_output_divider (
      .pclk     (pclk),
      .presetn  (presetn),
      .enable   (clock_output_enable),
      .usb_tick (usb_clk_tick),
      .duty     (clock_div_reg[DUTY_MSB:DUTY_LSB]),
      .ratio    (clock_div_reg[RATIO_MSB:RATIO_LSB]),
      .clk_out  (clock_output)
   );

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence get_cmd_write;
      psel && penable && pwrite && (paddr == OFS_COMMAND) && pstrb[LANE_CHIP] &&
      (pwdata[LANE_W-1:0] == CMD_GET_SETTINGS);
   endsequence

   sequence reply_read_done;
      psel && penable && !pwrite && (paddr == OFS_REPLY_HIGH);
   endsequence

   sequence reply_settled;
      ##1 (reply_state_reg == reply_full);
   endsequence

   a_reply_echo_ok: assert property (get_cmd_write |-> reply_settled ##0
         (reply_low_reg[7:0] == 8'h61) && (reply_low_reg[15:8] == 8'h00))
      else $error("reply echo or status byte wrong after command");
   a_reply_lengths: assert property (get_cmd_write |-> reply_settled ##0
         (reply_low_reg[23:16] == CHIP_AREA_LEN) && (reply_low_reg[31:24] == GP_AREA_LEN))
      else $error("reply length bytes wrong");
   a_reply_serial_bit: assert property (get_cmd_write |=>
         reply_high_reg[7] == $past(chip_byte_reg[7]))
      else $error("reply serial enable bit not from settings");
   a_rx_indicator_level: assert property (##1 rx_activity_indicator ==
         ($past(chip_byte_reg[6]) ^ $past(rx_busy)))
      else $error("receive indicator level wrong");
   a_tx_indicator_level: assert property (##1 tx_activity_indicator ==
         ($past(chip_byte_reg[5]) ^ $past(tx_busy)))
      else $error("transmit indicator level wrong");
   a_twowire_gated_level: assert property ((!twowire_indicator_enable &&
         $stable(chip_byte_reg)) |=>
         twowire_activity_indicator == $past(chip_byte_reg[BIT_TW_IDLE]))
      else $error("disabled two-wire indicator left idle level");
   a_suspend_indicator: assert property ((suspend_indicator_enable && usb_suspended &&
         $stable(chip_byte_reg)) |=>
         suspend_indicator == !$past(chip_byte_reg[BIT_SUSP_IDLE]))
      else $error("suspend indicator not inverted while suspended");
   a_enum_indicator: assert property ((enumeration_indicator_enable && usb_configured &&
         $stable(chip_byte_reg)) |=>
         enumeration_done_indicator == !$past(chip_byte_reg[BIT_ENUM_IDLE]))
      else $error("enumeration indicator not inverted once configured");
   a_security_code_legal: assert property (chip_byte_reg[1:0] != 2'b11)
      else $error("unused security code stored");
   a_reply_divider_byte: assert property (get_cmd_write |=>
         reply_high_reg[12:8] == $past(clock_div_reg))
      else $error("reply divider byte not from settings");
   a_reply_pad_zero: assert property (reply_high_reg[15:13] == 3'b000)
      else $error("reply byte 5 upper bits not zero");
   a_reply_snapshot_hold: assert property (!(psel && penable && pwrite &&
         (paddr == OFS_COMMAND)) |=> $stable(reply_low_reg) && $stable(reply_high_reg))
      else $error("reply changed without a new command");
   a_reply_read_clears: assert property (reply_read_done |=>
         (reply_state_reg == reply_empty))
      else $error("reply ready not cleared after reading the reply");
   a_locked_settings_kept: assert property ((chip_byte_reg[SEC_MSB:SEC_LSB] == sec_locked)
         |=> $stable(chip_byte_reg) && $stable(clock_div_reg))
      else $error("settings changed while locked");
   a_bad_code_refused: assert property ((setup_phase && pwrite &&
         (paddr == OFS_CHIP_SETTINGS) && pstrb[LANE_CHIP] &&
         (pwdata[SEC_MSB:SEC_LSB] == 2'b11)) |=> pslverr)
      else $error("unused security code not refused");

endmodule : sram_settings_readback

/* rtl/settings_readback_pkg.sv */
// Constants, field positions and types shared by the run-time settings readback block.
package settings_readback_pkg;

   // Register byte offsets on the APB bus.
   localparam logic [7:0] OFS_COMMAND       = 8'h00;
   localparam logic [7:0] OFS_CHIP_SETTINGS = 8'h04;
   localparam logic [7:0] OFS_REPLY_LOW     = 8'h08;
   localparam logic [7:0] OFS_REPLY_HIGH    = 8'h0c;
   localparam logic [7:0] OFS_STATUS        = 8'h10;

   // Command code and completion status carried in the reply.
   localparam logic [7:0] CMD_GET_SETTINGS = 8'h61;
   localparam logic [7:0] STATUS_SUCCESS   = 8'h00;

   // Field positions inside the chip settings byte (reply byte 4).
   localparam int BIT_SERIAL_EN  = 7;
   localparam int BIT_RX_IDLE    = 6;
   localparam int BIT_TX_IDLE    = 5;
   localparam int BIT_TW_IDLE    = 4;
   localparam int BIT_SUSP_IDLE  = 3;
   localparam int BIT_ENUM_IDLE  = 2;
   localparam int SEC_MSB        = 1;
   localparam int SEC_LSB        = 0;

   // Field positions inside the clock divider byte (reply byte 5).
   localparam int DIV_W          = 5;
   localparam int DUTY_MSB       = 4;
   localparam int DUTY_LSB       = 3;
   localparam int RATIO_MSB      = 2;
   localparam int RATIO_LSB      = 0;
   localparam int RATIO_W        = 3;
   localparam int DUTY_W         = 2;
   localparam int DIV_PAD_W      = 3;

   // Byte lanes of the 32-bit data bus, the status ready bit and the indicator count.
   localparam int LANE_W         = 8;
   localparam int LANE_DIV       = 1;
   localparam int LANE_CHIP      = 0;
   localparam int STAT_READY_BIT = 0;
   localparam int INDICATOR_N    = 5;

   // Reset values.
   localparam logic [7:0]       CHIP_BYTE_RESET = 8'h00;
   localparam logic [DIV_W-1:0] CLOCK_DIV_RESET = 5'h00;
   localparam logic [7:0]       COMMAND_RESET   = 8'h00;

   // Clock output source and divider geometry.
   localparam int USB_CLK_MHZ      = 48;
   localparam int DIV_PHASE_SHIFT  = 2;
   localparam int DIV_COUNT_MIN_W  = 9;

   typedef enum logic [1:0] {
      sec_unsecured = 2'b00,
      sec_password  = 2'b01,
      sec_locked    = 2'b10
   } security_type;

   typedef enum logic [0:0] {
      reply_empty = 1'b0,
      reply_full  = 1'b1
   } reply_state_type;

endpackage : settings_readback_pkg

/* rtl/clock_output_divider.sv */
// Divided clock output derived from the 48 MHz USB clock tick, with selectable duty cycle.
module clock_output_divider #(
   parameter int COUNT_W = 9
) (
   input  wire logic                                     pclk,
   input  wire logic                                     presetn,
   input  wire logic                                     enable,
   input  wire logic                                     usb_tick,
   input  wire logic [settings_readback_pkg::DUTY_W-1:0]  duty,
   input  wire logic [settings_readback_pkg::RATIO_W-1:0] ratio,
   output logic                                          clk_out
);
   import settings_readback_pkg::*;

   logic [COUNT_W-1:0] count_reg;
   logic [COUNT_W-1:0] count_next;
   logic [COUNT_W-1:0] period_mask;
   logic [COUNT_W-1:0] shifted;
   logic               clk_out_reg;

   generate
      if (COUNT_W < DIV_COUNT_MIN_W) begin : g_bad_width
         $error("clock_output_divider: COUNT_W too small for the largest ratio");
      end
   endgenerate

   // The period is 2^(ratio+2) source ticks so that the four duty phases are whole ticks.
   assign period_mask = COUNT_W'((32'd1 << (5'(ratio) + 5'(DIV_PHASE_SHIFT))) - 32'd1);
   assign count_next  = (count_reg + COUNT_W'(1)) & period_mask;
   assign shifted     = count_reg >> ratio;

   // Masking keeps the counter inside the period when software shortens the ratio.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= '0;
      end else if (!enable) begin
         count_reg <= '0;
      end else if (usb_tick) begin
         count_reg <= count_next;
      end
   end

   // Duty code n keeps the output high for n quarters of the period; code 0 holds it low.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_out_reg <= 1'b0;
      end else begin
         clk_out_reg <= enable && (shifted[1:0] < duty);
      end
   end

   assign clk_out = clk_out_reg;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_clock_idle_low: assert property (!enable |=> !clk_out)
      else $error("clock output not low while disabled");
   a_duty_zero_low: assert property ((duty == 2'b00) |=> !clk_out)
      else $error("clock output high with zero duty code");

endmodule : clock_output_divider

/* verif/usb_host_model.sv */
// Far-side host model: USB clock ticks and bus suspend/configured state.
module usb_host_model (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic suspend_req,
   input  wire logic configure_req,
   output logic      usb_clk_tick,
   output logic      usb_suspended,
   output logic      usb_configured
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] phase_reg;

   // A fractional accumulator gives 48 ticks per 125 pclk cycles, so ticks jitter by one cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_reg    <= 8'h00;
         usb_clk_tick <= 1'b0;
      end else if (phase_reg + 8'h30 >= 8'h7d) begin
         phase_reg    <= phase_reg + 8'h30 - 8'h7d;
         usb_clk_tick <= 1'b1;
      end else begin
         phase_reg    <= phase_reg + 8'h30;
         usb_clk_tick <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         usb_suspended  <= 1'b0;
         usb_configured <= 1'b0;
      end else begin
         usb_suspended  <= suspend_req;
         usb_configured <= configure_req;
      end
   end
endmodule : usb_host_model

/* verif/tb.sv */
// Self-checking testbench for the settings readback block.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import settings_readback_pkg::*;

   localparam logic [7:0] CHIP_LEN = 8'h16;
   localparam logic [7:0] GP_LEN   = 8'h04;

   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0]  pstrb = 4'h0, strb = 4'hf;
   logic        pready, pslverr, er, usb_clk_tick, usb_suspended, usb_configured;
   logic        rx_busy = 0, tx_busy = 0, twowire_busy = 0, susp_req = 0, cfg_req = 0;
   logic        tw_en = 0, susp_en = 0, enum_en = 0, clk_en = 0;
   logic [4:0]  ind;
   logic        serial_number_enable, clock_output;
   logic [1:0]  security_state;
   int          errors = 0, samples_checked = 0;

   always #4 pclk = ~pclk;

   usb_host_model i_host (.pclk(pclk), .presetn(presetn), .suspend_req(susp_req),
      .configure_req(cfg_req), .usb_clk_tick(usb_clk_tick), .usb_suspended(usb_suspended),
      .usb_configured(usb_configured));

   sram_settings_readback #(.CHIP_AREA_LEN(CHIP_LEN), .GP_AREA_LEN(GP_LEN)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_busy(rx_busy), .tx_busy(tx_busy), .twowire_busy(twowire_busy),
      .twowire_indicator_enable(tw_en), .usb_suspended(usb_suspended),
      .suspend_indicator_enable(susp_en), .usb_configured(usb_configured),
      .enumeration_indicator_enable(enum_en), .clock_output_enable(clk_en),
      .usb_clk_tick(usb_clk_tick), .rx_activity_indicator(ind[4]),
      .tx_activity_indicator(ind[3]), .twowire_activity_indicator(ind[2]),
      .suspend_indicator(ind[1]), .enumeration_done_indicator(ind[0]),
      .serial_number_enable(serial_number_enable), .security_state(security_state),
      .clock_output(clock_output));

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // One APB transfer; read data and error are taken at the edge where pready is sampled.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= strb;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) check("pready", 32'h1, 32'h0);
   endtask : apb

   task automatic t_reset();
      #1;
      check("indicators", 32'h0, 32'(ind));
      apb(1'b0, OFS_CHIP_SETTINGS, 32'h0);
      check("chip_reset", 32'h0, rd);
      apb(1'b0, OFS_STATUS, 32'h0);
      check("status_reset", 32'h0, rd);
      $display("test reset done");
   endtask : t_reset

   task automatic t_reply();
      logic [31:0] tbl [2] = '{32'h0000_ffd4, 32'h0000_0329};
      foreach (tbl[i]) begin
         apb(1'b1, OFS_CHIP_SETTINGS, tbl[i]);
         apb(1'b1, OFS_COMMAND, {24'h0, CMD_GET_SETTINGS});
         apb(1'b0, OFS_STATUS, 32'h0);
         check("status_ready", 32'h1, rd);
         apb(1'b0, OFS_REPLY_LOW, 32'h0);
         check("reply_low", {GP_LEN, CHIP_LEN, STATUS_SUCCESS, CMD_GET_SETTINGS}, rd);
         apb(1'b0, OFS_REPLY_HIGH, 32'h0);
         check("reply_high", {19'h0, tbl[i][12:0]}, rd);
         apb(1'b0, OFS_STATUS, 32'h0);
         check("status_clear", 32'h0, rd);
         check("serial_en", 32'(tbl[i][7]), 32'(serial_number_enable));
         check("security", 32'(tbl[i][1:0]), 32'(security_state));
      end
      $display("test reply done");
   endtask : t_reply

   task automatic t_indicators();
      apb(1'b1, OFS_CHIP_SETTINGS, 32'h0000_0054);
      for (int e = 0; e < 2; e++) begin
         for (int i = 0; i < 32; i++) begin
            @(posedge pclk);
            {rx_busy, tx_busy, twowire_busy, susp_req, cfg_req} <= i[4:0];
            {tw_en, susp_en, enum_en} <= {3{e[0]}};
            repeat (3) @(posedge pclk);
            #1;
            check("indicators", 32'(5'b10101 ^ (i[4:0] & {2'b11, {3{e[0]}}})), 32'(ind));
         end
      end
      @(posedge pclk);
      {rx_busy, tx_busy, twowire_busy, susp_req, cfg_req} <= 5'h00;
      $display("test indicators done");
   endtask : t_indicators

   task automatic t_clock();
      int rises;
      int highs;
      logic prev;
      // Duty 2, ratio 0: four-tick period, half high. Duty 1, ratio 1: eight ticks, quarter high.
      logic [31:0] cfg [2] = '{32'h0000_1000, 32'h0000_0900};
      int          rlo [2] = '{18, 9};
      int          rhi [2] = '{22, 11};
      int          hlo [2] = '{90, 44};
      int          hhi [2] = '{118, 60};
      foreach (cfg[k]) begin
         apb(1'b1, OFS_CHIP_SETTINGS, cfg[k]);
         clk_en <= 1'b1;
         repeat (16) @(posedge pclk);
         rises = 0;
         highs = 0;
         prev = 1'b1;
         repeat (208) begin
            @(posedge pclk);
            #1;
            if (clock_output === 1'b1 && prev === 1'b0) rises++;
            if (clock_output === 1'b1) highs++;
            prev = clock_output;
         end
         check("clk_rises_in_range", 32'h1, 32'(rises >= rlo[k] && rises <= rhi[k]));
         check("clk_duty_in_range", 32'h1, 32'(highs >= hlo[k] && highs <= hhi[k]));
      end
      @(posedge pclk);
      clk_en <= 1'b0;
      repeat (3) @(posedge pclk);
      highs = 0;
      repeat (40) begin
         @(posedge pclk);
         #1;
         if (clock_output !== 1'b0) highs++;
      end
      check("clk_off_highs", 32'h0, 32'(highs));
      $display("test clock done");
   endtask : t_clock

   task automatic t_refuse();
      apb(1'b1, OFS_COMMAND, 32'h0000_0060);
      apb(1'b0, OFS_COMMAND, 32'h0);
      check("command_kept", 32'h0000_0060, rd);
      apb(1'b0, OFS_STATUS, 32'h0);
      check("other_cmd_no_reply", 32'h0, rd);
      strb = 4'h2;
      apb(1'b1, OFS_CHIP_SETTINGS, 32'h0000_0bff);
      check("lane1_err", 32'h0, 32'(er));
      strb = 4'hf;
      apb(1'b0, OFS_CHIP_SETTINGS, 32'h0);
      check("lane1_only", 32'h0000_0b00, rd);
      apb(1'b0, 8'h20, 32'h0);
      check("unmapped_err", 32'h1, 32'(er));
      check("unmapped_data", 32'h0, rd);
      apb(1'b1, OFS_REPLY_LOW, 32'h1);
      check("ro_write_err", 32'h1, 32'(er));
      apb(1'b1, OFS_CHIP_SETTINGS, 32'h0000_0003);
      check("bad_sec_err", 32'h1, 32'(er));
      apb(1'b1, OFS_CHIP_SETTINGS, 32'h0000_0082);
      check("lock_err", 32'h0, 32'(er));
      apb(1'b1, OFS_CHIP_SETTINGS, 32'h0);
      check("locked_err", 32'h1, 32'(er));
      apb(1'b0, OFS_CHIP_SETTINGS, 32'h0);
      check("locked_value", 32'h0000_0082, rd);
      check("security", 32'(sec_locked), 32'(security_state));
      $display("test refuse done");
   endtask : t_refuse

   task automatic close_out();
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : close_out

   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_reply();
      t_indicators();
      t_clock();
      t_refuse();
      close_out();
   end

   initial begin
      repeat (5000) @(posedge pclk);
      errors++;
      close_out();
   end
endmodule : tb
